/* rtl/fbm_pkg.sv */
package fbm_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ   = 200;
  localparam int GAP_US    = 10;  // Idle time between poll rounds.
  localparam int GAP_CYC   = GAP_US * CLK_MHZ;
  localparam int BLINK_MS  = 250; // Half period of the blinking indicator.
  localparam int BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
  // ----------------------------------------
  // Bus limits
  // ----------------------------------------
  localparam logic [6:0] MAX_STATIONS = 7'd126;
  localparam logic [3:0] RATE_MAX     = 4'h9; // 9.6 kbit/s .. 12 Mbit/s.
  localparam int         NSLV         = 8;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_BUSPAR = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_IRQST  = 8'h0C;
  localparam logic [7:0] A_IRQMSK = 8'h10;
  localparam logic [7:0] A_SLVTAB = 8'h20;
  localparam logic [7:0] A_OUTA   = 8'h40;
  localparam logic [7:0] A_INA    = 8'h60;
  localparam int B_RUN = 0;
  localparam int B_COMMIT = 1;
  localparam int B_CFGOK = 2;
  localparam int I_ONLINE = 0;
  localparam int I_DX = 1;
  localparam int I_REJ = 2;
  localparam int I_RXERR = 3;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [1:0] GC_CLEAR   = 2'h1;
  localparam logic [1:0] GC_OPERATE = 2'h2;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_OFF    = 3'b001,
    ST_ONLINE = 3'b010,
    ST_DX     = 3'b100
  } fbm_state_e;
  typedef struct packed {
    logic        en;
    logic        failSafe;
    logic [3:0]  len;
    logic [6:0]  addr;
  } fbm_slv_s;
  typedef struct packed {
    logic        gc;
    logic [1:0]  cmd;
    logic [6:0]  addr;
    logic [3:0]  len;
    logic [31:0] data;
  } fbm_tel_s;
  typedef struct packed {
    logic [2:0]  idx;
    logic [31:0] data;
  } fbm_rx_s;
endpackage

/* rtl/fbm_state_ctrl.sv */
`timescale 1ns/1ps
// Behaviour
// - Reset leaves master off, indicators dark.
// - CPU hands bus parameters and configuration over.
// - Loaded parameters: go online, run lamp, address.
// - Online without project accepts fieldbus download.
// - Valid configuration starts cyclic exchange, lamp.
// - STOP broadcasts Clear, exchange lamp blinks.
// - STOP: fail-safe slaves get zero length.
// - STOP: other slaves get full zeroed data.
// - STOP: inputs still copied to input area.
// - RUN broadcasts Operate, exchange lamp steady.
// - RUN: slaves get latest CPU outputs.
// - RUN: slave inputs copied to input area.
// - At most 126 stations addressed.
// - One common rate, 9.6k to 12M.
module fbm_state_ctrl
  import fbm_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_CYC
) (
  // Clock, reset and enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Telegram stream towards the link layer
  output fbm_tel_s         txTel,
  output logic             txValid,
  input  wire logic        txReady,
  // Slave answers and fieldbus downloads
  input  fbm_rx_s          rxAns,
  input  wire logic        rxValid,
  input  wire logic        dlValid,
  // Indicators and link setup
  output logic             runLed,
  output logic             data_exchange_indicator,
  output logic [6:0]       ownAddr,
  output logic [3:0]       busRate,
  output logic             irq
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  fbm_state_e  state;
  logic        cpuRun;
  logic [6:0]  parAddr;
  logic [3:0]  parRate;
  logic [3:0]  irqSt;
  logic [3:0]  irqMsk;
  fbm_slv_s    slvTab [NSLV];
  logic [31:0] outArea [NSLV];
  logic [31:0] inArea [NSLV];
  logic [7:0]  awAddr;
  logic        awHeld;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        wHeld;
  logic [3:0]  pStep;
  logic [31:0] gapCnt;
  logic [31:0] blinkCnt;
  logic        blinkPh;

  logic        wrFire;
  logic        commit;
  logic        parOk;
  logic [3:0]  evt;
  logic [2:0]  wIdx;
  logic [2:0]  sIdx;
  logic [31:0] next_wval;
  logic [31:0] parWord;
  logic [31:0] slvWord;

  assign wIdx = awAddr[4:2];
  assign sIdx = 3'(pStep - 4'h1);
  assign wrFire = awHeld && wHeld && !s_axi_bvalid;
  assign commit = wrFire && awAddr == A_CTRL && wStrb[0] && wData[B_COMMIT];
  assign parOk = parAddr < MAX_STATIONS && parRate <= RATE_MAX;

  // Byte-lane merge of the held write onto an old value.
  function automatic logic [31:0] merge(input logic [31:0] old);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (wStrb[b]) begin
        v[b*8 +: 8] = wData[b*8 +: 8];
      end
    end
    return v;
  endfunction

  // ----------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------
  // Address and data are latched independently so either may come first.
  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !awHeld;
  assign s_axi_wready = !wHeld;
  assign s_axi_bresp = RESP_OK;
  assign next_wval = merge(32'h0000_0000);
  // Merged images of the bus parameter word and the addressed table slot.
  assign parWord = merge({20'h0_0000, parRate, 1'b0, parAddr});
  assign slvWord = merge(32'(slvTab[wIdx]));

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Control, bus parameters, mask and slave table writes.
  always_ff @(posedge clk) begin
    if (rst) begin
      cpuRun <= 1'b0;
      parAddr <= 7'h02;
      parRate <= 4'h0;
      irqMsk <= 4'h0;
      for (int i = 0; i < NSLV; i++) begin
        slvTab[i] <= '0;
        outArea[i] <= 32'h0000_0000;
      end
    end else if (ce && wrFire) begin
      if (awAddr == A_CTRL && wStrb[0]) begin
        cpuRun <= wData[B_RUN];
      end
      if (awAddr == A_BUSPAR) begin
        parAddr <= parWord[6:0];
        parRate <= parWord[11:8];
      end
      if (awAddr == A_IRQMSK) begin
        irqMsk <= next_wval[3:0];
      end
      if (awAddr[7:5] == A_SLVTAB[7:5]) begin
        slvTab[wIdx] <= slvWord[12:0];
      end
      if (awAddr[7:5] == A_OUTA[7:5]) begin
        outArea[wIdx] <= merge(outArea[wIdx]);
      end
    end
  end

  // ----------------------------------------
  // Master state
  // ----------------------------------------
  // A commit with good parameters brings the master online; a valid
  // project from the CPU or the fieldbus starts exchange. A commit with
  // bad parameters drops the master back off the bus.
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_OFF;
      ownAddr <= 7'h00;
      busRate <= 4'h0;
    end else if (ce) begin
      case (state)
        ST_OFF, ST_ONLINE, ST_DX: begin
          if (commit && parOk) begin
            ownAddr <= parAddr;
            busRate <= parRate;
            state <= wData[B_CFGOK] ? ST_DX : ST_ONLINE;
          end else if (commit) begin
            state <= ST_OFF;
          end else if (state == ST_ONLINE && dlValid) begin
            state <= ST_DX;
          end
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Poll engine
  // ----------------------------------------
  // Step 0 is the global control broadcast, steps 1..NSLV the slaves.
  // A telegram waits for txReady, so a slow link stretches the round.
  always_ff @(posedge clk) begin
    if (rst) begin
      pStep <= 4'h0;
      gapCnt <= 32'h0000_0000;
      txValid <= 1'b0;
      txTel <= '0;
    end else if (ce) begin
      if (state != ST_DX) begin
        pStep <= 4'h0;
        gapCnt <= 32'h0000_0000;
        txValid <= 1'b0;
      end else if (txValid) begin
        if (txReady) begin
          txValid <= 1'b0;
          pStep <= pStep + 4'h1;
        end
      end else if (pStep == 4'h0) begin
        if (gapCnt >= 32'(GAP_CYC)) begin
          gapCnt <= 32'h0000_0000;
          txValid <= 1'b1;
          txTel.gc <= 1'b1;
          txTel.cmd <= cpuRun ? GC_OPERATE : GC_CLEAR;
          txTel.addr <= MAX_STATIONS + 7'h1; // Broadcast address.
          txTel.len <= 4'h0;
          txTel.data <= 32'h0000_0000;
        end else begin
          gapCnt <= gapCnt + 32'h1;
        end
      end else if (pStep > 4'(NSLV)) begin
        pStep <= 4'h0;
      end else if (!slvTab[sIdx].en) begin
        pStep <= pStep + 4'h1;
      end else begin
        txValid <= 1'b1;
        txTel.gc <= 1'b0;
        txTel.cmd <= 2'h0;
        txTel.addr <= slvTab[sIdx].addr;
        if (cpuRun) begin
          txTel.len <= slvTab[sIdx].len;
          txTel.data <= outArea[sIdx];
        end else begin
          txTel.len <= slvTab[sIdx].failSafe ? 4'h0 : slvTab[sIdx].len;
          txTel.data <= 32'h0000_0000;
        end
      end
    end
  end

  // Answers land in the input area in either CPU state.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NSLV; i++) begin
        inArea[i] <= 32'h0000_0000;
      end
    end else if (ce && rxValid && state == ST_DX) begin
      inArea[rxAns.idx] <= rxAns.data;
    end
  end

  // ----------------------------------------
  // Indicators
  // ----------------------------------------
  // The blink counter runs only in exchange under STOP so each STOP starts lit.
  always_ff @(posedge clk) begin
    if (rst) begin
      blinkCnt <= 32'h0000_0000;
      blinkPh <= 1'b0;
      runLed <= 1'b0;
      data_exchange_indicator <= 1'b0;
    end else if (ce) begin
      if (state != ST_DX || cpuRun) begin
        blinkCnt <= 32'h0000_0000;
        blinkPh <= 1'b1;
      end else if (blinkCnt >= 32'(BLINK_CYCLES - 1)) begin
        blinkCnt <= 32'h0000_0000;
        blinkPh <= !blinkPh;
      end else begin
        blinkCnt <= blinkCnt + 32'h1;
      end
      runLed <= state != ST_OFF;
      if (state != ST_DX) begin
        data_exchange_indicator <= 1'b0;
      end else if (cpuRun) begin
        data_exchange_indicator <= 1'b1;
      end else begin
        data_exchange_indicator <= blinkPh;
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  // A new event wins over a write-one-to-clear in the same cycle.
  assign evt[I_ONLINE] = commit && parOk;
  assign evt[I_DX] = state == ST_ONLINE && dlValid;
  assign evt[I_REJ] = commit && !parOk;
  assign evt[I_RXERR] = rxValid && state != ST_DX;

  always_ff @(posedge clk) begin
    if (rst) begin
      irqSt <= 4'h0;
      irq <= 1'b0;
    end else if (ce) begin
      if (wrFire && awAddr == A_IRQST) begin
        irqSt <= (irqSt & ~next_wval[3:0]) | evt;
      end else begin
        irqSt <= irqSt | evt;
      end
      irq <= |(irqSt & irqMsk);
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  // One read at a time; data arrives the cycle after the address.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OK;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OK;
        s_axi_rdata <= 32'h0000_0000;
        case (s_axi_araddr[7:5])
          A_SLVTAB[7:5]: s_axi_rdata <= 32'(slvTab[s_axi_araddr[4:2]]);
          A_OUTA[7:5]: s_axi_rdata <= outArea[s_axi_araddr[4:2]];
          A_INA[7:5]: s_axi_rdata <= inArea[s_axi_araddr[4:2]];
          default: begin
            case (s_axi_araddr)
              A_CTRL: s_axi_rdata <= {31'h0, cpuRun};
              A_BUSPAR: s_axi_rdata <= {20'h0, parRate, 1'b0, parAddr};
              A_STATUS: s_axi_rdata <= {29'h0, state};
              A_IRQST: s_axi_rdata <= {28'h0, irqSt};
              A_IRQMSK: s_axi_rdata <= {28'h0, irqMsk};
              default: s_axi_rresp <= RESP_ERR;
            endcase
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

endmodule // fbm_state_ctrl

/* verif/fbm_state_ctrl_monitor.sv */
`timescale 1ns/1ps
module fbm_state_ctrl_monitor
  import fbm_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_CYC
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register bus answers
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Telegram link and indicators
  input fbm_tel_s         txTel,
  input wire logic        txValid,
  input wire logic        txReady,
  input wire logic        runLed,
  input wire logic        data_exchange_indicator,
  input wire logic [6:0]  ownAddr,
  input wire logic [3:0]  busRate
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A telegram taken by the link, and one that the link leaves waiting.
  sequence s_taken;
    txValid && txReady;
  endsequence
  sequence s_waiting;
    txValid && !txReady;
  endsequence
  // Reset is the one check that must run while reset is high.
  chk_reset_dark: assert property (disable iff (1'b0)
    rst |=> !runLed && !data_exchange_indicator && !txValid)
    else $error("Outputs not dark after reset.");
  chk_quiet_offline: assert property (
    !runLed |-> !data_exchange_indicator && !txValid)
    else $error("Exchange activity while offline.");
  chk_gc_form: assert property (
    txValid && txTel.gc |-> txTel.addr == 7'h7F
      && (txTel.cmd == GC_CLEAR || txTel.cmd == GC_OPERATE))
    else $error("Broadcast telegram malformed.");
  chk_tel_hold: assert property (s_waiting |=> txValid && $stable(txTel))
    else $error("Telegram dropped before acceptance.");
  chk_tel_gap: assert property (s_taken |=> !txValid)
    else $error("Telegram offered back to back.");
  chk_station_range: assert property (ownAddr < MAX_STATIONS)
    else $error("Station address out of range.");
  chk_rate_range: assert property (busRate <= RATE_MAX)
    else $error("Rate code out of range.");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late.");
  chk_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read answer dropped.");
  chk_write_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("Write answer dropped.");
endmodule // fbm_state_ctrl_monitor

bind fbm_state_ctrl fbm_state_ctrl_monitor #(.BLINK_CYCLES(BLINK_CYCLES)) i_mon (.*);

/* verif/fbm_link_partner.sv */
`timescale 1ns/1ps
module fbm_link_partner
  import fbm_pkg::*;
#(
  parameter logic [31:0] ANS = 32'hA500_0000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Telegrams in, answers out
  input  fbm_tel_s  txTel,
  input  wire logic txValid,
  output logic      txReady,
  output fbm_rx_s   rxAns,
  output logic      rxValid
);
  logic [3:0] lfsr;
  // Stall pattern; the station refuses telegrams whenever LFSR bits 0 and 3 are both low.
  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr <= 4'h1;
    end else begin
      lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
    end
  end
  assign txReady = lfsr[0] | lfsr[3];
  // Watchdog margin is left to the configurer; this station never times out.
  // Answer each slave telegram; idle lines toggle so nothing stale looks valid.
  always_ff @(posedge clk) begin
    rxValid <= 1'b0;
    rxAns   <= ~rxAns;
    if (rst) begin
      rxAns <= '0;
    end else if (txValid && txReady && !txTel.gc) begin
      rxValid <= 1'b1;
      rxAns   <= {txTel.addr[2:0], ANS ^ txTel.data ^ {25'h0, txTel.addr}};
    end
  end
endmodule // fbm_link_partner

/* verif/fbm_state_ctrl_bench.sv */
`timescale 1ns/1ps
module fbm_state_ctrl_bench;
  import fbm_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk, rst, ce, dlValid, irq, runLed, data_exchange_indicator;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, txValid, txReady, rxValid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, rdat;
  logic [31:0] outA [8];
  logic [12:0] slv [8];
  logic [3:0]  s_axi_wstrb, busRate, pr;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [6:0]  ownAddr, pa;
  fbm_tel_s    txTel;
  fbm_rx_s     rxAns;
  int          errors, cmp_count, i;
  int          sl [4] = '{0, 1, 3, 4};

  fbm_state_ctrl #(.BLINK_CYCLES(8)) i_fbm_state_ctrl (.*);
  fbm_link_partner i_fbm_link_partner (.*);

  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] expData(int k, bit r);
    return r ? outA[k] : 32'h0;
  endfunction
  function automatic logic [31:0] ans(int k, bit r);
    return 32'hA500_0000 ^ expData(k, r) ^ (k + 8);
  endfunction
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic conclude();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tmo();
    errors++;
    $display("[ERR] handshake expected done seen timeout");
    conclude();
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  // Bus cycles: each item held until its own ready is seen at an edge.
  task automatic wr(logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) tmo();
  endtask
  task automatic rd(logic [7:0] a);
    int n;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rdat = s_axi_rdata;
    rr   = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) tmo();
  endtask
  task automatic rchk(string s, logic [7:0] a, logic [31:0] e);
    rd(a);
    chk(s, e, rdat);
  endtask
  // Mode 0 dark, 1 steady on, 2 blinking with an 8-cycle half period.
  task automatic lamp(int m);
    int n, tg;
    logic p;
    tg = 0;
    p  = data_exchange_indicator;
    for (n = 0; n < 48; n++) begin
      @(posedge clk);
      if (data_exchange_indicator !== p) tg++;
      p = data_exchange_indicator;
    end
    if (m == 2) begin
      chk("lamp toggles", 1, 32'(tg inside {[5:6]}));
    end else begin
      chk("lamp toggles", 0, tg);
      chk("lamp level", m, p);
    end
  endtask
  // One poll round from the broadcast on; the first round after a change is stale.
  task automatic round(bit r, bit c);
    int n, k, s;
    fbm_tel_s t;
    k = -1;
    for (n = 0; n < 5000 && k < 4; n++) begin
      @(posedge clk);
      if (txValid && txReady) begin
        t = txTel;
        s = (k >= 0) ? sl[k] : 0;
        if (t.gc) begin
          k = 0;
          if (c) chk("gc cmd", r ? GC_OPERATE : GC_CLEAR, t.cmd);
        end else if (k >= 0) begin
          if (c) begin
            chk("slot addr", s + 8, t.addr);
            chk("slot len", (!r && slv[s][11]) ? 4'h0 : slv[s][10:7], t.len);
            chk("slot data", expData(s, r), t.data);
          end
          k++;
        end
      end
    end
    if (k < 4) tmo();
  endtask
  task automatic run(bit r);
    round(r, 1'b0);
    round(r, 1'b1);
    lamp(r ? 1 : 2);
    for (int k = 0; k < 4; k++) begin
      rchk("input area", A_INA + 8'(4 * sl[k]), ans(sl[k], r));
    end
    $display("Test exchange round done, run=%0d", r);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h0000_F372;
    errors = 0;
    cmp_count = 0;
    {rst, ce, s_axi_wstrb} = 6'h3F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, dlValid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rchk("status", A_STATUS, 32'h1);
    chk("lamps", 0, {runLed, data_exchange_indicator});
    rchk("bus params", A_BUSPAR, 32'h2);
    rchk("irq mask", A_IRQMSK, 32'h0);
    wr(8'hFC, 32'hFFFF_FFFF);
    rchk("unmapped", 8'hFC, 32'h0);
    chk("unmapped resp", RESP_ERR, rr);
    $display("Test reset done");
    // Station 126 and rate code 10 are refused.
    wr(A_IRQMSK, 32'hF);
    wr(A_BUSPAR, 32'h0000_037E);
    wr(A_CTRL, 32'h2);
    rchk("station limit", A_STATUS, 32'h1);
    wr(A_BUSPAR, 32'h0000_0A7D);
    wr(A_CTRL, 32'h2);
    rchk("rate limit", A_STATUS, 32'h1);
    rchk("reject flag", A_IRQST, 32'h4);
    chk("irq", 1, irq);
    wr(A_IRQST, 32'h4);
    cyc(2);
    chk("irq", 0, irq);
    $display("Test reject done");
    // Slot 2 and slots 5 to 7 are disabled; odd slots are fail-safe.
    pa = 7'(rnd() % 126);
    pr = 4'(rnd() % 10);
    for (i = 0; i < 8; i++) begin
      slv[i] = {1'(i != 2 && i < 5), 1'(i[0]), 4'(rnd()) | 4'h1, 7'(i + 8)};
      outA[i] = rnd();
      wr(A_SLVTAB + 8'(4 * i), 32'(slv[i]));
      wr(A_OUTA + 8'(4 * i), outA[i]);
    end
    wr(A_BUSPAR, {20'h0, pr, 1'b0, pa});
    wr(A_CTRL, 32'h2);
    rchk("online", A_STATUS, 32'h2);
    chk("run lamp", 1, runLed);
    chk("station", pa, ownAddr);
    chk("rate", pr, busRate);
    lamp(0);
    wr(A_IRQMSK, 32'h2);
    cyc(2);
    chk("masked irq", 0, irq);
    $display("Test online done");
    // Project download over the fieldbus.
    @(posedge clk);
    dlValid <= 1'b1;
    @(posedge clk);
    dlValid <= 1'b0;
    cyc(2);
    rchk("download", A_STATUS, 32'h4);
    chk("irq", 1, irq);
    wr(A_IRQST, 32'h3);
    cyc(2);
    chk("irq", 0, irq);
    run(0);
    wr(A_CTRL, 32'h1);
    run(1);
    outA[3] = rnd();
    wr(A_OUTA + 8'h0C, outA[3]);
    run(1);
    // A new configuration without and with the valid-configuration flag.
    wr(A_CTRL, 32'h3);
    rchk("new config", A_STATUS, 32'h2);
    lamp(0);
    wr(A_CTRL, 32'h7);
    rchk("config ok", A_STATUS, 32'h4);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    rchk("status", A_STATUS, 32'h1);
    chk("lamps", 0, {runLed, data_exchange_indicator});
    $display("Test reconfigure done");
    conclude();
  end
endmodule // fbm_state_ctrl_bench
